// ---- rtl/cdss_clock_divider.v ----
/*
 clock divider and source status: output divider control, sdram clock
 pin gating, system clock source select with power-down interlock.
 assumes a synchronous 16-bit word-addressed i/o port on ref_clk_in;
 the loop output arrives as a one-cycle tick, the system clock rate as a
 tick too; the loop power-down and select pin levels come from outside.
 reads and writes act at the edge where their strobe is high, and read
 data stands until the next read strobe.
*/
`timescale 1ns/100ps
`include "cdss_defs.vh"

// Behaviour
// (R01) Bit 9 of the output divider control chooses bypass (0) or the divider path (1).
// (R02) When enabled the divider divides the loop output by the 8-bit ratio plus one.
// (R03) With the pin enable set the sdram clock runs at system rate, or half in half-rate mode.
// (R04) With the pin enable clear, its reset value, the sdram clock pin is held low.
// (R05) Software resets the external memory interface after each pin enable change.
// (R06) Software sets the pin enable before any sdram access.
// (R07) Bits 5 to 4 of the select/status register report the actual clock source.
// (R08) A switch into loop mode is refused while loop power-down is asserted.
// (R09) Software never asserts loop power-down while already in loop mode.
// (R10) Source status reads 0 in bypass from rtc and 1 in loop mode fed by rtc.
// (R11) Software writes zeros to reserved bits 15 to 1 of the memory clock config.
// (R12) Status bit 2 mirrors the clock select pin, 0 rtc and 1 external input.
// (R13) Source status reads 2 in bypass from external input and 3 in loop mode fed by it.
// (R14) Select bit 0 picks bypass when 0 and loop mode when 1.
// (R15) Reserved bits read as zero and ignore writes.
module cdss_clock_divider
#(
	parameter RATIO_W = 8
)
(
	input  wire                     ref_clk_in,
	input  wire                     rst_in,
	input  wire [`CDSS_ADDR_W-1:0]  reg_addr_in,
	input  wire                     reg_wr_in,
	input  wire                     reg_rd_in,
	input  wire [`CDSS_DATA_W-1:0]  reg_wdata_in,
	output reg  [`CDSS_DATA_W-1:0]  reg_rdata_out,
	input  wire                     loop_clk_tick_in,
	input  wire                     system_clock_tick_in,
	input  wire                     half_rate_mode_in,
	input  wire                     loop_power_down_in,
	input  wire                     clock_select_pin_in,
	output reg                      loop_out_tick_out,
	output reg                      sdram_clock_pin_out,
	output reg                      loop_mode_active_out
);

	localparam DATA_W = `CDSS_DATA_W;
	// reset words split per field; constants, so fit for the async branch
	localparam [DATA_W-1:0] MEM_CLK_CFG_RST  = `CDSS_MEM_CLK_CFG_RST;
	localparam [DATA_W-1:0] SYS_CLK_SEL_RST  = `CDSS_SYS_CLK_SEL_RST;
	localparam [DATA_W-1:0] OUT_DIV_CTRL_RST = `CDSS_OUT_DIV_CTRL_RST;

	reg                 sdram_clock_pin_enable;
	reg                 system_clock_source_select;
	reg                 output_divider_enable;
	reg  [RATIO_W-1:0]  output_divide_ratio;
	reg  [RATIO_W-1:0]  div_count;
	reg                 half_phase;
	reg                 next_loop_mode;
	reg  [1:0]          system_clock_source_status;
	reg  [DATA_W-1:0]   next_rdata;
	wire                sel_mem;
	wire                sel_sys;
	wire                sel_div;
	wire                wr_mem;
	wire                wr_sys;
	wire                wr_div;

	assign sel_mem = (reg_addr_in == `CDSS_OFF_MEM_CLK_CFG);
	assign sel_sys = (reg_addr_in == `CDSS_OFF_SYS_CLK_SEL);
	assign sel_div = (reg_addr_in == `CDSS_OFF_OUT_DIV_CTRL);
	assign wr_mem  = reg_wr_in && sel_mem;
	assign wr_sys  = reg_wr_in && sel_sys;
	assign wr_div  = reg_wr_in && sel_div;

	// only the documented bits are stored; the rest never hold state
	// a read in the same cycle as a write still sees the old value
	always @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			sdram_clock_pin_enable     <= MEM_CLK_CFG_RST[`CDSS_BIT_SDRAM_CLOCK_PIN_ENABLE];
			system_clock_source_select <= SYS_CLK_SEL_RST[`CDSS_BIT_SRC_SELECT];
			output_divider_enable      <= OUT_DIV_CTRL_RST[`CDSS_BIT_OUT_DIV_EN];
			output_divide_ratio        <= OUT_DIV_CTRL_RST[RATIO_W-1:0];
		end
		else
		begin
			if (wr_mem)
				sdram_clock_pin_enable <= reg_wdata_in[`CDSS_BIT_SDRAM_CLOCK_PIN_ENABLE]; // R15
			if (wr_sys)
				system_clock_source_select <= reg_wdata_in[`CDSS_BIT_SRC_SELECT]; // R14
			if (wr_div)
			begin
				output_divider_enable <= reg_wdata_in[`CDSS_BIT_OUT_DIV_EN]; // R01
				output_divide_ratio   <= reg_wdata_in[RATIO_W-1:0]; // R02
			end
		end
	end

	// interlock only guards entry; leaving loop mode on power-down is software's job
	always @*
	begin
		next_loop_mode = loop_mode_active_out;
		if (!system_clock_source_select)
			next_loop_mode = 1'b0; // R14
		else if (!loop_mode_active_out && !loop_power_down_in)
			next_loop_mode = 1'b1; // R08
	end

	// status follows this flop, so entry shows one cycle after the select
	always @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
			loop_mode_active_out <= 1'b0;
		else
			loop_mode_active_out <= next_loop_mode;
	end

	// divider counts loop ticks; ratio 0 passes every tick
	// a ratio rewritten below the running count ends that count at once
	always @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			div_count         <= {RATIO_W{1'b0}};
			loop_out_tick_out <= 1'b0;
		end
		else if (!output_divider_enable)
		begin
			div_count         <= {RATIO_W{1'b0}};
			loop_out_tick_out <= loop_clk_tick_in; // R01
		end
		else if (loop_clk_tick_in)
		begin
			if (div_count >= output_divide_ratio)
			begin
				div_count         <= {RATIO_W{1'b0}};
				loop_out_tick_out <= 1'b1; // R02
			end
			else
			begin
				div_count         <= div_count + 1'b1;
				loop_out_tick_out <= 1'b0;
			end
		end
		else
			loop_out_tick_out <= 1'b0;
	end

	// the pin toggles per system tick; half rate drops every other toggle.
	// not glitch-free on enable change, hence the memory interface reset.
	always @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			sdram_clock_pin_out <= 1'b0;
			half_phase          <= 1'b0;
		end
		else if (!sdram_clock_pin_enable)
		begin
			sdram_clock_pin_out <= 1'b0; // R04
			half_phase          <= 1'b0;
		end
		else if (system_clock_tick_in)
		begin
			half_phase <= ~half_phase;
			if (!half_rate_mode_in || half_phase)
				sdram_clock_pin_out <= ~sdram_clock_pin_out; // R03
		end
	end

	// codes come from the defines rather than from bit order
	always @*
	begin
		case ({clock_select_pin_in, loop_mode_active_out})
			2'h0:    system_clock_source_status = `CDSS_SRC_BYPASS_RTC; // R10
			2'h1:    system_clock_source_status = `CDSS_SRC_LOOP_RTC; // R10
			2'h2:    system_clock_source_status = `CDSS_SRC_BYPASS_EXT; // R13
			2'h3:    system_clock_source_status = `CDSS_SRC_LOOP_EXT; // R13
			default: system_clock_source_status = `CDSS_SRC_BYPASS_RTC;
		endcase
	end

	// one mux for all views; reserved and unmapped bits stay zero
	always @*
	begin
		next_rdata = {DATA_W{1'b0}}; // R15
		case (reg_addr_in)
			`CDSS_OFF_MEM_CLK_CFG:
				next_rdata[`CDSS_BIT_SDRAM_CLOCK_PIN_ENABLE] = sdram_clock_pin_enable;
			`CDSS_OFF_SYS_CLK_SEL:
			begin
				next_rdata[`CDSS_BIT_SRC_STAT_HI:`CDSS_BIT_SRC_STAT_LO] =
					system_clock_source_status; // R07
				next_rdata[`CDSS_BIT_SEL_PIN_STAT] = clock_select_pin_in; // R12
				next_rdata[`CDSS_BIT_SRC_SELECT]   = system_clock_source_select; // R14
			end
			`CDSS_OFF_OUT_DIV_CTRL:
			begin
				next_rdata[`CDSS_BIT_OUT_DIV_EN] = output_divider_enable; // R01
				next_rdata[RATIO_W-1:0]          = output_divide_ratio; // R02
			end
			default:
				next_rdata = {DATA_W{1'b0}}; // R15
		endcase
	end

	// read data stands until the next read strobe
	always @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
			reg_rdata_out <= {DATA_W{1'b0}};
		else if (reg_rd_in)
			reg_rdata_out <= next_rdata;
	end

endmodule

// ---- rtl/cdss_defs.vh ----
/*
 defines for the clock divider and source status block: word offsets,
 field positions, reset values and status codes.
 assumes a 16-bit cpu i/o register port with word addresses.
*/
`ifndef CDSS_DEFS_VH
`define CDSS_DEFS_VH

`define CDSS_ADDR_W              16
`define CDSS_DATA_W              16
`define CDSS_OFF_MEM_CLK_CFG     16'h1C1E
`define CDSS_OFF_SYS_CLK_SEL     16'h1C1F
`define CDSS_OFF_OUT_DIV_CTRL    16'h1C23

`define CDSS_MEM_CLK_CFG_RST     16'h0000
`define CDSS_SYS_CLK_SEL_RST     16'h0000
`define CDSS_OUT_DIV_CTRL_RST    16'h0000

`define CDSS_BIT_SDRAM_CLOCK_PIN_ENABLE        0
`define CDSS_BIT_SRC_SELECT      0
`define CDSS_BIT_SEL_PIN_STAT    2
`define CDSS_BIT_SRC_STAT_LO     4
`define CDSS_BIT_SRC_STAT_HI     5
`define CDSS_BIT_OUT_DIV_EN      9
`define CDSS_BIT_RATIO_LO        0
`define CDSS_BIT_RATIO_HI        7

`define CDSS_SRC_BYPASS_RTC      2'h0
`define CDSS_SRC_LOOP_RTC        2'h1
`define CDSS_SRC_BYPASS_EXT      2'h2
`define CDSS_SRC_LOOP_EXT        2'h3

`endif

// ---- dv/cdss_checker.sv ----
/* port assertions for cdss_clock_divider.
 assumes binding onto that module and a bench that stays quiet in reset. */
`timescale 1ns/100ps
`include "cdss_defs.vh"
module cdss_checker
(
	input wire        ref_clk_in,
	input wire        rst_in,
	input wire [15:0] reg_addr_in,
	input wire        reg_wr_in,
	input wire        reg_rd_in,
	input wire [15:0] reg_wdata_in,
	input wire [15:0] reg_rdata_out,
	input wire        loop_clk_tick_in,
	input wire        system_clock_tick_in,
	input wire        loop_power_down_in,
	input wire        clock_select_pin_in,
	input wire        loop_out_tick_out,
	input wire        sdram_clock_pin_out,
	input wire        loop_mode_active_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	wire st = reg_rd_in && reg_addr_in == `CDSS_OFF_SYS_CLK_SEL;
	wire go = reg_wr_in && reg_addr_in == `CDSS_OFF_SYS_CLK_SEL && reg_wdata_in[0];
	wire pd = loop_power_down_in;
	wire lm = loop_mode_active_out;
	wire off = reg_wr_in && reg_addr_in == `CDSS_OFF_MEM_CLK_CFG && !reg_wdata_in[0];
	enter_loop_a: assert property (
		go && !pd ##1 !pd |=> lm) else $error("no loop entry");
	refuse_loop_a: assert property ($rose(lm) |-> !$past(pd))
		else $error("entry in power-down");
	pin_edge_a: assert property (
		$rose(sdram_clock_pin_out) |-> $past(system_clock_tick_in))
		else $error("pin edge without tick");
	out_tick_a: assert property (loop_out_tick_out |-> $past(loop_clk_tick_in))
		else $error("stray out tick");
	rdata_hold_a: assert property (!$past(reg_rd_in) |-> $stable(reg_rdata_out))
		else $error("read data moved");
	status_rsv_a: assert property ($past(st) |-> reg_rdata_out[15:6] == 10'h000
		&& !reg_rdata_out[3] && !reg_rdata_out[1]) else $error("reserved bits set");
	pin_stat_a: assert property ($past(st) |->
		reg_rdata_out[2] == $past(clock_select_pin_in)
		&& reg_rdata_out[5] == $past(clock_select_pin_in)) else $error("pin status");
	src_stat_a: assert property ($past(st) |-> reg_rdata_out[4] == $past(lm))
		else $error("source status");
	pin_off_a: assert property (off |-> ##2 !sdram_clock_pin_out)
		else $error("pin not held low");
	cover property ($rose(lm));
	cover property (go && pd);
	cover property (loop_out_tick_out);
	cover property ($rose(sdram_clock_pin_out));
endmodule
bind cdss_clock_divider cdss_checker u_cdss_checker (.*);

// ---- dv/cdss_clock_divider_test.sv ----
/* self-checking bench for cdss_clock_divider.
 assumes the bound checker; inputs move on the falling edge. */
`timescale 1ns/100ps
module cdss_clock_divider_test;
	reg         ref_clk_in = 0;
	reg         rst_in = 1;
	reg         wr = 0, rd = 0, lt = 0, st = 0, hr = 0, pd = 0, sp = 0;
	reg  [15:0] ad = 0, wd = 0;
	wire [15:0] q;
	wire        ot, pin, lm;
	integer     num_errors = 0, num_checks = 0, cyc = 0, co, cp;
	cdss_clock_divider u_cdss_clock_divider
	(
		.ref_clk_in, .rst_in, .reg_addr_in(ad), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_wdata_in(wd), .reg_rdata_out(q), .loop_clk_tick_in(lt),
		.system_clock_tick_in(st), .half_rate_mode_in(hr), .loop_power_down_in(pd),
		.clock_select_pin_in(sp), .loop_out_tick_out(ot), .sdram_clock_pin_out(pin),
		.loop_mode_active_out(lm)
	);
	always #12.5 ref_clk_in = ~ref_clk_in;
	task end_sim;
	begin
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	end
	endtask
	always @(posedge ref_clk_in)
	begin
		cyc = cyc + 1;
		// whole run is under 800 cycles
		if (cyc == 3000)
		begin
			num_errors = num_errors + 1;
			end_sim;
		end
	end
	task chk(input [15:0] seen, input [15:0] exp);
	begin
		num_checks = num_checks + 1;
		if (seen !== exp)
		begin
			num_errors = num_errors + 1;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	end
	endtask
	task wrt(input [15:0] a, input [15:0] d);
	begin
		@(negedge ref_clk_in);
		ad = a;
		wd = d;
		wr = 1;
		@(negedge ref_clk_in);
		wr = 0;
	end
	endtask
	task rdc(input [15:0] a, input [15:0] e);
	begin
		@(negedge ref_clk_in);
		ad = a;
		rd = 1;
		@(negedge ref_clk_in);
		rd = 0;
		chk(q, e);
	end
	endtask
	// n ticks on both tick inputs, then 3 idle cycles so late outputs are counted
	task run(input integer n);
		reg     pv;
		integer i;
	begin
		co = 0;
		cp = 0;
		pv = pin;
		for (i = 0; i < n + 3; i = i + 1)
		begin
			@(negedge ref_clk_in);
			co = co + ot;
			cp = cp + (pin !== pv);
			pv = pin;
			lt = i < n;
			st = i < n;
		end
	end
	endtask
	initial
	begin
		repeat (16) @(posedge ref_clk_in);
		@(negedge ref_clk_in);
		rst_in = 0;
		chk({13'h0, ot, pin, lm}, 16'h0000);
		rdc(16'h1C1E, 16'h0000);
		rdc(16'h1C1F, 16'h0000);
		rdc(16'h1C23, 16'h0000);
		rdc(16'h1C20, 16'h0000);
		$display("reset test done");
		wrt(16'h1C23, 16'hFFFF);
		rdc(16'h1C23, 16'h02FF);
		run(512);
		chk(co[15:0], 16'h0002);
		wrt(16'h1C23, 16'h0202);
		run(9);
		chk(co[15:0], 16'h0003);
		wrt(16'h1C23, 16'h00FF);
		run(5);
		chk(co[15:0], 16'h0005);
		$display("divider test done");
		run(8);
		chk(cp[15:0], 16'h0000);
		wrt(16'h1C1E, 16'h0001);
		rdc(16'h1C1E, 16'h0001);
		run(8);
		chk(cp[15:0], 16'h0008);
		hr = 1;
		run(6);
		chk(cp[15:0], 16'h0003);
		chk({15'h0000, pin}, 16'h0001);
		wrt(16'h1C1E, 16'h0000);
		run(2);
		chk({15'h0000, pin}, 16'h0000);
		$display("sdram pin test done");
		sp = 1;
		pd = 1;
		wrt(16'h1C1F, 16'h0001);
		rdc(16'h1C1F, 16'h0025);
		chk({15'h0000, lm}, 16'h0000);
		pd = 0;
		wrt(16'h1C1F, 16'hFFFF);
		run(0);
		chk({15'h0000, lm}, 16'h0001);
		rdc(16'h1C1F, 16'h0035);
		sp = 0;
		run(0);
		rdc(16'h1C1F, 16'h0011);
		wrt(16'h1C1F, 16'h0000);
		run(0);
		rdc(16'h1C1F, 16'h0000);
		$display("source test done");
		end_sim;
	end
endmodule
